// ==== pwmb_defs.svh ====
// pwmb_defs.svh: offsets, field positions, reset values and timing counts of the bridge steering block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef PWMB_DEFS_SVH
`define PWMB_DEFS_SVH

// ==========================================================
// register byte offsets
`define PWMB_OFS_CTRL 8'h00
`define PWMB_OFS_DUTY 8'h04
`define PWMB_OFS_PERIOD 8'h08
`define PWMB_OFS_DEAD 8'h0C
`define PWMB_OFS_STATUS 8'h10

// ==========================================================
// field positions
`define PWMB_CTRL_CFG 1:0
`define PWMB_CTRL_POL 2
`define PWMB_CTRL_PRE 4:3
`define PWMB_DUTY_F 9:0
`define PWMB_PERIOD_F 7:0
`define PWMB_DEAD_F 6:0

// ==========================================================
// reset values
`define PWMB_RST_CFG 2'h0
`define PWMB_RST_PRE 2'h0
`define PWMB_RST_DUTY 10'h000
`define PWMB_RST_PERIOD 8'hFF
`define PWMB_RST_DEAD 7'h00

// ==========================================================
// prescale codes and last sub-count of one timer step
`define PWMB_PRE_DIV1 2'h0
`define PWMB_PRE_DIV4 2'h1
`define PWMB_STEP_DIV1 6'h03
`define PWMB_STEP_DIV4 6'h0F
`define PWMB_STEP_DIV16 6'h3F

// ==========================================================
// timing: one instruction cycle is four oscillator periods
`define PWMB_TOSC_NS 25
`define PWMB_CLK_NS 25
`define PWMB_TCY_TOSC 4
`define PWMB_TCY_CLKS ((`PWMB_TCY_TOSC * `PWMB_TOSC_NS) / `PWMB_CLK_NS)

`endif

// ==== pwmb_pkg.sv ====
// pwmb_pkg.sv: types of the bridge steering block.
// Assumes pwmb_defs.svh is on the include path.
`include "pwmb_defs.svh"

package pwmb_pkg;

  // ==========================================================
  // output configuration codes
  typedef enum logic [1:0] {
    PWMB_SINGLE = 2'b00,
    PWMB_FWD = 2'b01,
    PWMB_HALF = 2'b10,
    PWMB_REV = 2'b11
  } pwmb_mode_e;

  // ==========================================================
  // whole state of the block
  typedef struct packed {
    logic [1:0] ctrlCfg;
    logic ctrlPol;
    logic [1:0] ctrlPre;
    logic [9:0] duty;
    logic [7:0] period;
    logic [6:0] dead;
    logic [1:0] shCfg;
    logic shPol;
    logic [1:0] shPre;
    logic [9:0] shDuty;
    logic [6:0] shDead;
    logic [5:0] cnt;
    logic [7:0] timer;
    logic pwm;
    logic [8:0] dlyA;
    logic [8:0] dlyB;
    logic [3:0] outs;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] rdata;
  } pwmb_state_s;

endpackage

// ==== pwmb_bridge.sv ====
// pwmb_bridge.sv: PWM base waveform and four-output bridge steering with an AHB-Lite register slave.
// Assumes clk_sys is the oscillator, a single AHB-Lite master, and external pin direction control.
//
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pwmb_defs.svh"

module pwmb_bridge (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // bridge drive outputs
  output logic bridge_out_a,
  output logic bridge_out_b,
  output logic bridge_out_c,
  output logic bridge_out_d
);

  // ==========================================================
  // helper functions

  // last sub-count of one timer step for a prescale code
  function automatic logic [5:0] stepMax(input logic [1:0] pre);
    case (pre)
      `PWMB_PRE_DIV1: stepMax = `PWMB_STEP_DIV1;
      `PWMB_PRE_DIV4: stepMax = `PWMB_STEP_DIV4;
      default: stepMax = `PWMB_STEP_DIV16;
    endcase
  endfunction

  // two low-order bits that extend the timer for the duty compare
  function automatic logic [1:0] subBits(input logic [5:0] cnt, input logic [1:0] pre);
    case (pre)
      `PWMB_PRE_DIV1: subBits = cnt[1:0];
      `PWMB_PRE_DIV4: subBits = cnt[3:2];
      default: subBits = cnt[5:4];
    endcase
  endfunction

  // dead-band counter step: restarts while the target is inactive, saturates at the limit
  function automatic logic [8:0] dbStep(input logic target, input logic [8:0] cur, input logic [8:0] lim);
    if (!target) begin
      dbStep = 9'h000;
    end else if (cur < lim) begin
      dbStep = cur + 9'h001;
    end else begin
      dbStep = cur;
    end
  endfunction

  // ==========================================================
  // state and decoded terms
  pwmb_pkg::pwmb_state_s s, next_s;
  logic busAct;
  logic lastTick;
  logic periodStart;
  logic pendDir;
  logic guard;
  logic fullMode;
  logic newDir;
  logic [8:0] dbClks;
  logic actA, actB, lvlMod;
  logic dutyHit; // duty compare true in this clock
  logic pwmLive; // waveform with the duty match applied in the same clock
  logic [3:0] rawOuts;
  logic [31:0] readVal;

  // ==========================================================
  // combinational next state
  always_comb begin
    next_s = s;
    busAct = hsel && hready && htrans[1];
    // register writes land in the data phase
    if (s.wrPend) begin
      case (s.wrAddr)
        `PWMB_OFS_CTRL: begin
          next_s.ctrlCfg = hwdata[`PWMB_CTRL_CFG];
          next_s.ctrlPol = hwdata[`PWMB_CTRL_POL];
          next_s.ctrlPre = hwdata[`PWMB_CTRL_PRE];
        end
        `PWMB_OFS_DUTY: next_s.duty = hwdata[`PWMB_DUTY_F];
        `PWMB_OFS_PERIOD: next_s.period = hwdata[`PWMB_PERIOD_F];
        `PWMB_OFS_DEAD: next_s.dead = hwdata[`PWMB_DEAD_F];
        default: ;
      endcase
    end
    next_s.wrPend = busAct && hwrite;
    next_s.wrAddr = haddr[7:0];
    // read data captured in the address phase, shown in the data phase
    case (haddr[7:0])
      `PWMB_OFS_CTRL: readVal = {27'h000_0000, s.ctrlPre, s.ctrlPol, s.ctrlCfg};
      `PWMB_OFS_DUTY: readVal = {22'h00_0000, s.duty};
      `PWMB_OFS_PERIOD: readVal = {24'h00_0000, s.period};
      `PWMB_OFS_DEAD: readVal = {25'h000_0000, s.dead};
      `PWMB_OFS_STATUS: readVal = {18'h0_0000, s.timer, s.outs, s.shCfg};
      default: readVal = 32'h0000_0000;
    endcase
    if (busAct && !hwrite) begin
      next_s.rdata = readVal;
    end
    // timebase: one timer step is four clocks times the prescale
    lastTick = s.cnt == stepMax(s.shPre);
    periodStart = lastTick && (s.timer == s.period);
    next_s.cnt = lastTick ? 6'h00 : s.cnt + 6'h01;
    if (periodStart) begin
      next_s.timer = 8'h00;
    end else if (lastTick) begin
      next_s.timer = s.timer + 8'h01;
    end
    // shadow copies reload only on the period boundary
    if (periodStart) begin
      next_s.shCfg = s.ctrlCfg;
      next_s.shPol = s.ctrlPol;
      next_s.shPre = s.ctrlPre;
      next_s.shDuty = s.duty;
      next_s.shDead = s.dead;
    end
    // duty match: the waveform drops in the clock of the match, so a duty of n lasts n sub-steps exactly
    dutyHit = {s.timer, subBits(s.cnt, s.shPre)} == s.shDuty;
    pwmLive = s.pwm && !dutyHit;
    // base waveform: set at period start unless duty is zero, clear on match
    if (periodStart) begin
      next_s.pwm = s.duty != `PWMB_RST_DUTY;
    end else if (dutyHit) begin
      next_s.pwm = 1'b0;
    end
    // dead-band counters time only the rising edge of each half-bridge target
    // at-or-above compare: a count left over from a longer dead-band must not lock an output off
    dbClks = 9'(s.shDead * `PWMB_TCY_CLKS);
    next_s.dlyA = dbStep(pwmLive, s.dlyA, dbClks);
    next_s.dlyB = dbStep(!pwmLive, s.dlyB, dbClks);
    actA = pwmLive && (s.dlyA >= dbClks);
    actB = !pwmLive && (s.dlyB >= dbClks);
    // direction change: pending while software direction differs from the live one
    fullMode = s.shCfg[0];
    newDir = s.ctrlCfg[1];
    pendDir = fullMode && s.ctrlCfg[0] && (newDir != s.shCfg[1]);
    guard = pendDir && (s.timer == s.period);
    lvlMod = pwmLive && !guard;
    // steering, outputs ordered {d, c, b, a}, one meaning active
    case (pwmb_pkg::pwmb_mode_e'(s.shCfg))
      pwmb_pkg::PWMB_HALF: rawOuts = {2'b00, actB, actA};
      pwmb_pkg::PWMB_FWD: begin
        if (guard) begin
          rawOuts = 4'b0100;
        end else begin
          rawOuts = {lvlMod, 2'b00, 1'b1};
        end
      end
      pwmb_pkg::PWMB_REV: begin
        if (guard) begin
          rawOuts = 4'b0001;
        end else begin
          rawOuts = {1'b0, 1'b1, lvlMod, 1'b0};
        end
      end
      default: rawOuts = {3'b000, pwmLive};
    endcase
    next_s.outs = rawOuts ^ {4{s.shPol}};
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s <= '{ctrlCfg: `PWMB_RST_CFG, ctrlPol: 1'b0, ctrlPre: `PWMB_RST_PRE, duty: `PWMB_RST_DUTY,
             period: `PWMB_RST_PERIOD, dead: `PWMB_RST_DEAD, shCfg: `PWMB_RST_CFG, shPol: 1'b0,
             shPre: `PWMB_RST_PRE, shDuty: `PWMB_RST_DUTY, shDead: `PWMB_RST_DEAD, cnt: 6'h00,
             timer: 8'h00, pwm: 1'b0, dlyA: 9'h000, dlyB: 9'h000, outs: 4'h0, wrPend: 1'b0,
             wrAddr: 8'h00, rdata: 32'h0000_0000};
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // port drive: always ready, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign bridge_out_a = s.outs[0];
  assign bridge_out_b = s.outs[1];
  assign bridge_out_c = s.outs[2];
  assign bridge_out_d = s.outs[3];

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_shadow_hold: assert property (!periodStart |=> $stable(s.shCfg) && $stable(s.shDuty))
    else $error("shadow settings changed away from the period boundary");

  chk_pwm_start: assert property (periodStart && s.duty != 10'h000 |=> s.pwm)
    else $error("waveform not set at period start");

  // outputs lag one clock, so levels are judged against the polarity that built them
  // half-bridge: never both outputs of the pair active
  chk_half_pair: assert property (s.shCfg == pwmb_pkg::PWMB_HALF
    |=> !((s.outs[0] ^ $past(s.shPol)) && (s.outs[1] ^ $past(s.shPol))))
    else $error("half-bridge outputs both active");

  // a nonzero dead-band holds a inactive on the waveform rise
  chk_dead_wait: assert property (s.shCfg == pwmb_pkg::PWMB_HALF && $rose(s.pwm) && s.shDead != 7'h00
    |=> (s.outs[0] == $past(s.shPol)))
    else $error("output went active before the dead-band elapsed");

  // full-bridge: never more than two outputs active
  chk_full_two: assert property (fullMode |=> $countones(s.outs ^ {4{$past(s.shPol)}}) <= 2)
    else $error("more than two bridge outputs active");

  // forward: a active, b and c inactive, d follows the waveform
  chk_fwd_steer: assert property (s.shCfg == pwmb_pkg::PWMB_FWD && !guard
    |=> s.outs[2:0] == (3'b001 ^ {3{$past(s.shPol)}}) && (s.outs[3] == ($past(pwmLive) ^ $past(s.shPol))))
    else $error("forward steering wrong");

  // reverse: c active, a and d inactive, b follows the waveform
  chk_rev_steer: assert property (s.shCfg == pwmb_pkg::PWMB_REV && !guard
    |=> s.outs[3] == $past(s.shPol) && s.outs[2] != $past(s.shPol) && s.outs[0] == $past(s.shPol)
    && s.outs[1] == ($past(pwmLive) ^ $past(s.shPol)))
    else $error("reverse steering wrong");

  // guard step: both modulated outputs inactive
  chk_guard_mod: assert property (guard |=> s.outs[1] == $past(s.shPol) && s.outs[3] == $past(s.shPol))
    else $error("modulated output active in guard step");

  chk_guard_len: assert property (guard && lastTick |=> !guard)
    else $error("guard step did not end at the period boundary");

  // single output: b, c and d rest at the inactive level
  chk_single_pol: assert property (s.shCfg == pwmb_pkg::PWMB_SINGLE
    |=> s.outs[3:1] == {3{$past(s.shPol)}})
    else $error("unused outputs not at inactive level");

  // control, polarity and prescale copies follow the written values at the boundary
  chk_cfg_apply: assert property (periodStart
    |=> s.shCfg == $past(s.ctrlCfg) && s.shPol == $past(s.ctrlPol) && s.shPre == $past(s.ctrlPre))
    else $error("control copy not taken at the period boundary");

  // duty and dead-band copies follow the written values at the boundary
  chk_duty_apply: assert property (periodStart |=> s.shDuty == $past(s.duty) && s.shDead == $past(s.dead))
    else $error("duty or dead-band copy not taken at the period boundary");

  // a zero duty keeps the waveform low for the whole period
  chk_pwm_zero: assert property (periodStart && s.duty == `PWMB_RST_DUTY |=> !s.pwm)
    else $error("waveform set with zero duty");

  // the waveform drops on the duty match
  chk_pwm_clear: assert property (dutyHit && !periodStart |=> !s.pwm)
    else $error("waveform not cleared on duty match");

  // half-bridge: b stays inactive while the waveform is high
  chk_half_b: assert property (s.shCfg == pwmb_pkg::PWMB_HALF && pwmLive
    |=> s.outs[1] == $past(s.shPol))
    else $error("half-bridge b active while the waveform is high");

  // half-bridge: a stays inactive while the waveform is low
  chk_half_a: assert property (s.shCfg == pwmb_pkg::PWMB_HALF && !pwmLive
    |=> s.outs[0] == $past(s.shPol))
    else $error("half-bridge a active while the waveform is low");

  // half-bridge: c and d are left at the inactive level
  chk_half_cd: assert property (s.shCfg == pwmb_pkg::PWMB_HALF |=> s.outs[3:2] == {2{$past(s.shPol)}})
    else $error("half-bridge drives c or d");

  // zero dead-band: a follows the waveform with no wait
  chk_dead_zero: assert property (s.shCfg == pwmb_pkg::PWMB_HALF && s.shDead == `PWMB_RST_DEAD
    |=> s.outs[0] == ($past(pwmLive) ^ $past(s.shPol)))
    else $error("a delayed with a zero dead-band");

  // the fall of the waveform is never delayed
  chk_dead_fall: assert property (s.shCfg == pwmb_pkg::PWMB_HALF && $fell(pwmLive)
    |=> s.outs[0] == $past(s.shPol))
    else $error("a stayed active after the waveform fell");

  // a dead-band not yet run out keeps a inactive, even past the end of the duty
  chk_dead_long: assert property (s.shCfg == pwmb_pkg::PWMB_HALF && s.dlyA < dbClks
    |=> s.outs[0] == $past(s.shPol))
    else $error("a active before its dead-band ran out");

  // full-bridge: the modulated output goes active at once on the waveform rise
  chk_full_nodb: assert property (s.shCfg == pwmb_pkg::PWMB_FWD && !guard && $rose(pwmLive)
    |=> s.outs[3] != $past(s.shPol))
    else $error("dead-band delay seen in full-bridge mode");

  // full-bridge: the live direction only moves at the boundary
  chk_dir_hold: assert property (fullMode && !periodStart |=> $stable(s.shCfg))
    else $error("direction changed inside a period");

  // guard leaving forward: c already active, a already inactive
  chk_guard_rev: assert property (guard && s.shCfg == pwmb_pkg::PWMB_FWD
    |=> s.outs[2] != $past(s.shPol) && s.outs[0] == $past(s.shPol))
    else $error("unmodulated pair not switched to reverse in guard step");

  // guard leaving reverse: a already active, c already inactive
  chk_guard_fwd: assert property (guard && s.shCfg == pwmb_pkg::PWMB_REV
    |=> s.outs[0] != $past(s.shPol) && s.outs[2] == $past(s.shPol))
    else $error("unmodulated pair not switched to forward in guard step");

  // the guard lies inside the last timer step, whose length follows the prescale
  chk_guard_step: assert property (guard |-> s.timer == s.period && s.cnt <= stepMax(s.shPre))
    else $error("guard outside the last timer step");

  // the sub-count restarts after the prescale's last value
  chk_step_wrap: assert property (lastTick |=> s.cnt == 6'h00)
    else $error("sub-count did not restart after a timer step");

endmodule

`default_nettype wire

// ==== pwmb_switch_model.sv ====
// pwmb_switch_model.sv: external power switch drivers of the bridge.
// Assumes leg one is switched by outputs a and b, leg two by c and d.
`timescale 1ns/1ps
`default_nettype none
module pwmb_switch_model (
  // clock, reset and polarity
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic activeLow,
  // drive inputs
  input wire logic driveA,
  input wire logic driveB,
  input wire logic driveC,
  input wire logic driveD,
  // cycles with both switches of one leg on
  output logic [15:0] shootCount
);
  // every drive counts as driven: pin directions are set by software beforehand
  logic shoot;
  // ==========================================================
  // shoot-through watch: both switches of a leg on
  assign shoot = ((driveA ^ activeLow) && (driveB ^ activeLow)) || ((driveC ^ activeLow) && (driveD ^ activeLow));
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      shootCount <= 16'h0000;
    end else if (shoot) begin
      shootCount <= shootCount + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ==== pwm_half_full_bridge_steering_test.sv ====
// pwm_half_full_bridge_steering_test.sv: register and output-steering tests of the bridge block.
// Assumes pwmb_bridge, pwmb_switch_model and pwmb_defs.svh; AHB-Lite master is this bench.
`timescale 1ns/1ps
`default_nettype none
`include "pwmb_defs.svh"
module pwm_half_full_bridge_steering_test;
  logic clkSys = 1'b0, resetN = 1'b0, hsel = 1'b0, hwrite = 1'b0, pol = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd, cnt [4];
  logic hreadyout, hresp, outA, outB, outC, outD;
  logic [15:0] shootCount, shoot0;
  int errTotal = 0, samplesChecked = 0, f;
  // ==========================================================
  // clock, design and switch model
  always #12.5 clkSys = ~clkSys;
  pwmb_bridge i_dut (.clk_sys(clkSys), .reset_n(resetN), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .bridge_out_a(outA), .bridge_out_b(outB), .bridge_out_c(outC),
    .bridge_out_d(outD));
  pwmb_switch_model i_sw (.clk_sys(clkSys), .reset_n(resetN), .activeLow(pol), .driveA(outA),
    .driveB(outB), .driveC(outC), .driveD(outD), .shootCount(shootCount));
  // ==========================================================
  // bus cycles: hold each phase until hready is seen high
  task automatic waitReady();
    int n;
    n = 0;
    @(posedge clkSys);
    while (hreadyout !== 1'b1 && n < 100) begin
      n++;
      @(posedge clkSys);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
    rd = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samplesChecked++;
    if (g !== e) begin
      errTotal++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    chk("register", e, rd);
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask
  // count high cycles of each output over n clocks
  task automatic measure(input int n);
    for (int k = 0; k < 4; k++) cnt[k] = 32'h0000_0000;
    repeat (n) begin
      cnt[0] += 32'(outA);
      cnt[1] += 32'(outB);
      cnt[2] += 32'(outC);
      cnt[3] += 32'(outD);
      @(posedge clkSys);
      #1;
    end
  endtask
  task automatic outChk(input string nm, input logic [31:0] a, b, c, d);
    chk({nm, " a"}, a, cnt[0]);
    chk({nm, " b"}, b, cnt[1]);
    chk({nm, " c"}, c, cnt[2]);
    chk({nm, " d"}, d, cnt[3]);
    $display("test %s done", nm);
  endtask
  task automatic run(input logic [7:0] a, input logic [31:0] d, input int n);
    ahb(1'b1, a, d);
    repeat (40) @(posedge clkSys);
    #1;
    measure(n);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clkSys);
    errTotal++;
    summarize();
  end
  // ==========================================================
  // test sequence
  initial begin
    repeat (10) @(posedge clkSys);
    resetN <= 1'b1;
    rdChk(`PWMB_OFS_CTRL, 32'h0000_0000);
    rdChk(`PWMB_OFS_PERIOD, 32'h0000_00FF);
    rdChk(`PWMB_OFS_DEAD, 32'h0000_0000);
    ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
    rdChk(8'h20, 32'h0000_0000);
    ahb(1'b1, `PWMB_OFS_PERIOD, 32'h0000_0003);
    run(`PWMB_OFS_DUTY, 32'h0000_0000, 64);
    outChk("duty zero", 0, 0, 0, 0);
    run(`PWMB_OFS_DUTY, 32'h0000_0014, 64);
    outChk("duty over", 64, 0, 0, 0);
    run(`PWMB_OFS_DUTY, 32'h0000_0006, 64);
    outChk("single", 24, 0, 0, 0);
    ahb(1'b1, `PWMB_OFS_CTRL, 32'h0000_0002);
    for (int k = 0; k < 3; k++) begin
      run(`PWMB_OFS_DEAD, 32'(k), 64);
      outChk("half", 24 - 16 * k + 8 * (k / 2), 40 - 16 * k, 0, 0);
    end
    pol = 1'b1;
    run(`PWMB_OFS_CTRL, 32'h0000_0005, 64);
    outChk("fwd low", 0, 64, 64, 40);
    pol = 1'b0;
    run(`PWMB_OFS_CTRL, 32'h0000_0003, 64);
    outChk("rev", 0, 24, 64, 0);
    for (int p = 0; p < 3; p++) begin
      f = 1 << (2 * p);
      run(`PWMB_OFS_CTRL, {27'h000_0000, p[1:0], 3'h1}, 600);
      for (int n = 0; n < 1000 && !(outD === 1'b1 && cnt[3] == 32'h0000_0000); n++) begin
        cnt[3] = 32'(outD);
        @(posedge clkSys);
        #1;
      end
      shoot0 = shootCount;
      fork
        ahb(1'b1, `PWMB_OFS_CTRL, {27'h000_0000, p[1:0], 3'h3});
        measure(32 * f);
      join
      outChk("turn", 12 * f, 6 * f, 20 * f, 6 * f);
      chk("shoot", {16'h0000, shoot0}, {16'h0000, shootCount});
    end
    rdChk(`PWMB_OFS_DUTY, 32'h0000_0006);
    summarize();
  end
endmodule
`default_nettype wire
